// >>> acw_pkg.sv
package acw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ACW_OFS_CTRL_ENABLE = 8'h00;
  localparam logic [7:0] ACW_OFS_CTRL_CLOCK_DIVIDER = 8'h01;
  localparam logic [7:0] ACW_OFS_CTRL_REFERENCE_TIMEBASE = 8'h02;
  localparam logic [7:0] ACW_OFS_CTRL_WINDOW_COMPARE = 8'h03;
  localparam logic [7:0] ACW_OFS_IRQ_ENABLE = 8'h04;
  localparam logic [7:0] ACW_OFS_IRQ_FLAGS = 8'h05;
  localparam logic [7:0] ACW_OFS_CONVERTER_STATUS = 8'h06;
  localparam logic [7:0] ACW_OFS_RESULT_LO = 8'h10;
  localparam logic [7:0] ACW_OFS_RESULT_HI = 8'h11;
  localparam logic [7:0] ACW_OFS_SAMPLE_LO = 8'h14;
  localparam logic [7:0] ACW_OFS_SAMPLE_HI = 8'h15;
  localparam logic [7:0] ACW_OFS_LOW_THRESH_LO = 8'h1c;
  localparam logic [7:0] ACW_OFS_LOW_THRESH_HI = 8'h1d;
  localparam logic [7:0] ACW_OFS_HIGH_THRESH_LO = 8'h1e;
  localparam logic [7:0] ACW_OFS_HIGH_THRESH_HI = 8'h1f;

  localparam logic [7:0] ACW_RST_REG = 8'h00;
  localparam logic [15:0] ACW_RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ACW_ENABLE_BIT = 0;
  localparam int ACW_DIV_LSB = 0;
  localparam int ACW_DIV_MSB = 3;
  localparam int ACW_REF_LSB = 0;
  localparam int ACW_REF_MSB = 2;
  localparam int ACW_TB_LSB = 3;
  localparam int ACW_TB_MSB = 7;
  localparam int ACW_WCM_LSB = 0;
  localparam int ACW_WCM_MSB = 2;
  localparam int ACW_WSRC_BIT = 3;
  localparam int ACW_BUSY_BIT = 0;

  localparam int ACW_IRQ_RESULT_READY = 0;
  localparam int ACW_IRQ_SAMPLE_READY = 1;
  localparam int ACW_IRQ_WINDOW_MATCH = 2;
  localparam int ACW_IRQ_RESULT_OVERWRITE = 3;
  localparam int ACW_IRQ_SAMPLE_OVERWRITE = 4;
  localparam int ACW_IRQ_TRIGGER_OVERRUN = 5;
  localparam logic [7:0] ACW_IRQ_MASK = 8'h3f;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] ACW_REF_SUPPLY = 3'h0;
  localparam logic [2:0] ACW_REF_EXTERNAL = 3'h2;
  localparam logic [2:0] ACW_REF_INT_1V024 = 3'h4;
  localparam logic [2:0] ACW_REF_INT_2V048 = 3'h5;
  localparam logic [2:0] ACW_REF_INT_2V500 = 3'h6;
  localparam logic [2:0] ACW_REF_INT_4V096 = 3'h7;

  localparam logic [2:0] ACW_WCM_NONE = 3'h0;
  localparam logic [2:0] ACW_WCM_BELOW = 3'h1;
  localparam logic [2:0] ACW_WCM_ABOVE = 3'h2;
  localparam logic [2:0] ACW_WCM_INSIDE = 3'h3;
  localparam logic [2:0] ACW_WCM_OUTSIDE = 3'h4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ACW_CLK_MHZ = 10;
  localparam int ACW_REF_INIT_US = 60;
  localparam logic [7:0] ACW_REF_INIT_TICKS = 8'(ACW_REF_INIT_US);
  localparam logic [6:0] ACW_ONE = 7'h01;

  typedef enum logic [1:0] {
    ACW_IDLE = 2'b00,
    ACW_SETTLE = 2'b01,
    ACW_CONVERT = 2'b11
  } acw_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } acw_bus_req_t;

  typedef struct packed {
    logic sample_done;
    logic result_done;
    logic [15:0] sample;
    logic [15:0] result;
  } acw_conv_ret_t;

endpackage : acw_pkg

// >>> acw_control.sv
`timescale 1ns/1ns
// Contract
// - converter clock is peripheral clock divided per 4-bit code, 2 to 64
// - 5-bit timebase gives cycles per microsecond for internal guard delays
// - reference code: 0 supply, 2 external, 4-7 internal; 1 and 3 reserved
// - switching to an internal reference waits 60 us before conversion
// - window source bit 3 picks result or sample low 16 bits
// - window mode: off, below, above, inside, outside; others reserved
// - window compares 16-bit values with strict inequalities
// - six interrupt enables; a source requests only when flag and enable set
// - flags share enable positions; write one clears, write zero keeps
// - trigger during running conversion sets trigger overrun
// - new sample over unread sample sets sample overwrite
// - new result over unread result sets result overwrite
// - window match flag set at completion when mode condition holds
// - sample ready set per sample; cleared by write one or sample read
// - result ready set per result; cleared by write one or result read
// - busy bit 0 high while converting or settling
// - no conversions and no flags while global enable is clear
module acw_control
  import acw_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire acw_bus_req_t bus_in,
  output logic [7:0] rdata_out,
  input wire logic trigger_in,
  input wire acw_conv_ret_t conv_in,
  output logic conv_start_out,
  output logic adc_clk_tick_out,
  output logic [2:0] reference_selector_out,
  output logic busy_out,
  output logic irq_out
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic enable;
  logic [3:0] clock_divider_code;
  logic [7:0] ctrl_reference_timebase;
  logic [7:0] ctrl_window_compare;
  logic [7:0] irq_enable;
  logic [7:0] irq_flags;
  logic [15:0] window_low_threshold;
  logic [15:0] window_high_threshold;
  logic [15:0] result_value;
  logic [15:0] sample_value;
  logic result_unread;
  logic sample_unread;
  acw_state_t state;

  logic wr;
  logic rd;
  logic [2:0] reference_selector;
  logic [4:0] timebase;
  logic [2:0] window_compare_mode;
  logic window_source_select;

  assign wr = bus_in.wr;
  assign rd = bus_in.rd;
  assign reference_selector = ctrl_reference_timebase[ACW_REF_MSB:ACW_REF_LSB];
  assign timebase = ctrl_reference_timebase[ACW_TB_MSB:ACW_TB_LSB];
  assign window_compare_mode = ctrl_window_compare[ACW_WCM_MSB:ACW_WCM_LSB];
  assign window_source_select = ctrl_window_compare[ACW_WSRC_BIT];

  // ----------------------------------------------------------------
  // software writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      enable <= 1'b0;
      clock_divider_code <= 4'h0;
      ctrl_reference_timebase <= ACW_RST_REG;
      ctrl_window_compare <= ACW_RST_REG;
      irq_enable <= ACW_RST_REG;
      window_low_threshold <= ACW_RST_WORD;
      window_high_threshold <= ACW_RST_WORD;
    end
    else if (wr)
    begin
      case (bus_in.addr)
        ACW_OFS_CTRL_ENABLE: enable <= bus_in.wdata[ACW_ENABLE_BIT];
        ACW_OFS_CTRL_CLOCK_DIVIDER:
          clock_divider_code <= bus_in.wdata[ACW_DIV_MSB:ACW_DIV_LSB];
        ACW_OFS_CTRL_REFERENCE_TIMEBASE: ctrl_reference_timebase <= bus_in.wdata;
        ACW_OFS_CTRL_WINDOW_COMPARE: ctrl_window_compare <= bus_in.wdata & 8'h0f;
        ACW_OFS_IRQ_ENABLE: irq_enable <= bus_in.wdata & ACW_IRQ_MASK;
        ACW_OFS_LOW_THRESH_LO: window_low_threshold[7:0] <= bus_in.wdata;
        ACW_OFS_LOW_THRESH_HI: window_low_threshold[15:8] <= bus_in.wdata;
        ACW_OFS_HIGH_THRESH_LO: window_high_threshold[7:0] <= bus_in.wdata;
        ACW_OFS_HIGH_THRESH_HI: window_high_threshold[15:8] <= bus_in.wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // converter clock prescaler
  // ----------------------------------------------------------------
  logic [6:0] div_ratio;
  logic [6:0] div_count;

  always_comb
  begin
    if (!clock_divider_code[3])
      div_ratio = 7'({clock_divider_code[2:0], 1'b0}) + 7'd2;
    else if (!clock_divider_code[2])
      div_ratio = 7'({clock_divider_code[1:0], 2'b00}) + 7'd20;
    else
      div_ratio = 7'({clock_divider_code[1:0], 3'b000}) + 7'd40;
  end

  // tick only while enabled so a disabled converter sees no clock
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable)
    begin
      div_count <= 7'h00;
      adc_clk_tick_out <= 1'b0;
    end
    else if (div_count >= div_ratio - ACW_ONE)
    begin
      div_count <= 7'h00;
      adc_clk_tick_out <= 1'b1;
    end
    else
    begin
      div_count <= div_count + ACW_ONE;
      adc_clk_tick_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // microsecond timebase and reference settling
  // ----------------------------------------------------------------
  logic [4:0] us_count;
  logic us_tick;
  logic [7:0] settle_left;
  logic ref_write;
  logic [2:0] new_ref;
  logic ref_internal_change;

  assign ref_write = wr && (bus_in.addr == ACW_OFS_CTRL_REFERENCE_TIMEBASE);
  assign new_ref = bus_in.wdata[ACW_REF_MSB:ACW_REF_LSB];
  // top bit set selects one of the four internal references
  assign ref_internal_change = ref_write && new_ref[2] && (new_ref != reference_selector);

  // period of timebase cycles; zero treated as one so the delay still ends
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || ref_internal_change)
    begin
      us_count <= 5'h00;
      us_tick <= 1'b0;
    end
    else if (us_count + 5'h01 >= timebase)
    begin
      us_count <= 5'h00;
      us_tick <= 1'b1;
    end
    else
    begin
      us_count <= us_count + 5'h01;
      us_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      settle_left <= 8'h00;
    else if (ref_internal_change)
      settle_left <= ACW_REF_INIT_TICKS;
    else if (us_tick && settle_left != 8'h00)
      settle_left <= settle_left - 8'h01;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      reference_selector_out <= ACW_REF_SUPPLY;
    else
      reference_selector_out <= reference_selector;
  end

  // ----------------------------------------------------------------
  // conversion sequencing
  // ----------------------------------------------------------------
  logic trig_overrun;
  logic trig_take;

  assign trig_take = enable && trigger_in;
  assign trig_overrun = trig_take && (state == ACW_CONVERT);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !enable)
    begin
      state <= ACW_IDLE;
      conv_start_out <= 1'b0;
    end
    else
    begin
      conv_start_out <= 1'b0;
      case (state)
        ACW_IDLE:
          if (trig_take)
          begin
            if (settle_left != 8'h00 || ref_internal_change)
              state <= ACW_SETTLE;
            else
            begin
              state <= ACW_CONVERT;
              conv_start_out <= 1'b1;
            end
          end
        ACW_SETTLE:
          // a second trigger while waiting merges with the first
          if (settle_left == 8'h00 && !ref_internal_change)
          begin
            state <= ACW_CONVERT;
            conv_start_out <= 1'b1;
          end
        ACW_CONVERT:
          if (conv_in.result_done)
            state <= ACW_IDLE;
        default: state <= ACW_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      busy_out <= 1'b0;
    else
      busy_out <= (state != ACW_IDLE) || (settle_left != 8'h00);
  end

  // ----------------------------------------------------------------
  // data latches and unread tracking
  // ----------------------------------------------------------------
  logic sample_ev;
  logic result_ev;
  logic sample_read;
  logic result_read;

  assign sample_ev = enable && conv_in.sample_done;
  assign result_ev = enable && conv_in.result_done;
  assign sample_read = rd && (bus_in.addr == ACW_OFS_SAMPLE_LO
                              || bus_in.addr == ACW_OFS_SAMPLE_HI);
  assign result_read = rd && (bus_in.addr == ACW_OFS_RESULT_LO
                              || bus_in.addr == ACW_OFS_RESULT_HI);

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      sample_value <= ACW_RST_WORD;
      sample_unread <= 1'b0;
    end
    else if (sample_ev)
    begin
      sample_value <= conv_in.sample;
      sample_unread <= 1'b1;
    end
    else if (sample_read)
      sample_unread <= 1'b0;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      result_value <= ACW_RST_WORD;
      result_unread <= 1'b0;
    end
    else if (result_ev)
    begin
      result_value <= conv_in.result;
      result_unread <= 1'b1;
    end
    else if (result_read)
      result_unread <= 1'b0;
  end

  // ----------------------------------------------------------------
  // window comparator
  // ----------------------------------------------------------------
  logic [15:0] win_value;
  logic win_event;
  logic below_low;
  logic above_high;
  logic win_hit;

  // compares the value arriving now, i.e. the register content after update
  assign win_value = window_source_select ? conv_in.sample : conv_in.result;
  assign win_event = window_source_select ? sample_ev : result_ev;
  assign below_low = win_value < window_low_threshold;
  assign above_high = win_value > window_high_threshold;

  always_comb
  begin
    case (window_compare_mode)
      ACW_WCM_BELOW: win_hit = below_low;
      ACW_WCM_ABOVE: win_hit = above_high;
      ACW_WCM_INSIDE: win_hit = (win_value > window_low_threshold) && (win_value < window_high_threshold);
      ACW_WCM_OUTSIDE: win_hit = below_low || above_high;
      default: win_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt flags
  // ----------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;

  always_comb
  begin
    flag_set = 8'h00;
    flag_set[ACW_IRQ_TRIGGER_OVERRUN] = trig_overrun;
    flag_set[ACW_IRQ_SAMPLE_OVERWRITE] = sample_ev && sample_unread;
    flag_set[ACW_IRQ_RESULT_OVERWRITE] = result_ev && result_unread;
    flag_set[ACW_IRQ_WINDOW_MATCH] = win_event && win_hit;
    flag_set[ACW_IRQ_SAMPLE_READY] = sample_ev;
    flag_set[ACW_IRQ_RESULT_READY] = result_ev;
    flag_clr = 8'h00;
    if (wr && bus_in.addr == ACW_OFS_IRQ_FLAGS)
      flag_clr = bus_in.wdata & ACW_IRQ_MASK;
    flag_clr[ACW_IRQ_SAMPLE_READY] = flag_clr[ACW_IRQ_SAMPLE_READY] | sample_read;
    flag_clr[ACW_IRQ_RESULT_READY] = flag_clr[ACW_IRQ_RESULT_READY] | result_read;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      irq_flags <= ACW_RST_REG;
    else
      irq_flags <= (irq_flags & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_flags & irq_enable);
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;

  always_comb
  begin
    case (bus_in.addr)
      ACW_OFS_CTRL_ENABLE: next_rdata = {7'h00, enable};
      ACW_OFS_CTRL_CLOCK_DIVIDER: next_rdata = {4'h0, clock_divider_code};
      ACW_OFS_CTRL_REFERENCE_TIMEBASE: next_rdata = ctrl_reference_timebase;
      ACW_OFS_CTRL_WINDOW_COMPARE: next_rdata = ctrl_window_compare;
      ACW_OFS_IRQ_ENABLE: next_rdata = irq_enable;
      ACW_OFS_IRQ_FLAGS: next_rdata = irq_flags;
      ACW_OFS_CONVERTER_STATUS: next_rdata = {7'h00, busy_out};
      ACW_OFS_RESULT_LO: next_rdata = result_value[7:0];
      ACW_OFS_RESULT_HI: next_rdata = result_value[15:8];
      ACW_OFS_SAMPLE_LO: next_rdata = sample_value[7:0];
      ACW_OFS_SAMPLE_HI: next_rdata = sample_value[15:8];
      ACW_OFS_LOW_THRESH_LO: next_rdata = window_low_threshold[7:0];
      ACW_OFS_LOW_THRESH_HI: next_rdata = window_low_threshold[15:8];
      ACW_OFS_HIGH_THRESH_LO: next_rdata = window_high_threshold[7:0];
      ACW_OFS_HIGH_THRESH_HI: next_rdata = window_high_threshold[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  // data only in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || !rd)
      rdata_out <= 8'h00;
    else
      rdata_out <= next_rdata;
  end

endmodule : acw_control

// >>> acw_control_checker.sv
`timescale 1ns/1ns
module acw_control_checker
  import acw_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire acw_bus_req_t bus_in,
  input wire logic [7:0] rdata_out,
  input wire logic trigger_in,
  input wire acw_conv_ret_t conv_in,
  input wire logic conv_start_out,
  input wire logic adc_clk_tick_out,
  input wire logic [2:0] reference_selector_out,
  input wire logic busy_out,
  input wire logic irq_out
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic en_q;
  logic armed;
  logic [3:0] div_q;
  logic [7:0] gap;
  logic [7:0] ratio;
  logic cfg_wr;

  assign cfg_wr = bus_in.wr && (bus_in.addr == ACW_OFS_CTRL_ENABLE ||
                                bus_in.addr == ACW_OFS_CTRL_CLOCK_DIVIDER);
  assign ratio = (div_q < 4'h8) ? 8'(div_q) * 8'h02 + 8'h02 :
                 (div_q < 4'hc) ? 8'(div_q) * 8'h04 - 8'h0c : 8'(div_q) * 8'h08 - 8'h38;

  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      en_q <= 1'b0;
      div_q <= 4'h0;
    end
    else if (bus_in.wr && bus_in.addr == ACW_OFS_CTRL_ENABLE)
      en_q <= bus_in.wdata[0];
    else if (bus_in.wr && bus_in.addr == ACW_OFS_CTRL_CLOCK_DIVIDER)
      div_q <= bus_in.wdata[3:0];
  end

  // period only judged between two ticks of one unchanged setting
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in || cfg_wr)
    begin
      armed <= 1'b0;
      gap <= 8'h00;
    end
    else if (adc_clk_tick_out)
    begin
      armed <= 1'b1;
      gap <= 8'h01;
    end
    else if (gap != 8'hff)
      gap <= gap + 8'h01;
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  AST_TICK_PERIOD: assert property (
    armed |-> (adc_clk_tick_out ? gap == ratio : gap < ratio))
    else $error("converter clock tick period wrong");
  AST_START_BUSY: assert property (
    conv_start_out |=> !conv_start_out && busy_out)
    else $error("start pulse not followed by busy");
  AST_STATUS_READ: assert property (
    bus_in.rd && bus_in.addr == ACW_OFS_CONVERTER_STATUS |=> rdata_out == {7'h00, $past(busy_out)})
    else $error("status read does not show busy");
  AST_IRQ_MASKED: assert property (
    bus_in.wr && bus_in.addr == ACW_OFS_IRQ_ENABLE && bus_in.wdata[5:0] == 6'h00 |-> ##2 !irq_out)
    else $error("interrupt high with all enables clear");
  AST_REF_COPY: assert property (
    bus_in.wr && bus_in.addr == ACW_OFS_CTRL_REFERENCE_TIMEBASE
    |-> ##2 reference_selector_out == $past(bus_in.wdata[2:0], 2))
    else $error("reference selector output wrong");
  AST_OFF_QUIET: assert property (
    !en_q && !$past(en_q) |-> !conv_start_out && !adc_clk_tick_out)
    else $error("activity while disabled");
  AST_SETTLE_BUSY: assert property (
    bus_in.wr && bus_in.addr == ACW_OFS_CTRL_REFERENCE_TIMEBASE && bus_in.wdata[2] &&
    !reference_selector_out[2] && en_q |-> ##2 busy_out [*8])
    else $error("no settling after internal reference select");
  AST_IDLE_START: assert property (
    trigger_in && en_q && !busy_out && !conv_start_out && !bus_in.wr && !$past(bus_in.wr)
    |=> conv_start_out)
    else $error("idle trigger did not start a conversion");
endmodule : acw_control_checker

bind acw_control acw_control_checker u_checker (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .trigger_in(trigger_in), .conv_in(conv_in), .conv_start_out(conv_start_out),
  .adc_clk_tick_out(adc_clk_tick_out), .reference_selector_out(reference_selector_out),
  .busy_out(busy_out), .irq_out(irq_out)
);

// >>> adc_control_window_irq_bench.sv
`timescale 1ns/1ns
module adc_control_window_irq_bench;
  import acw_pkg::*;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic clk_sys_in;
  logic rst_in;
  logic trigger_in;
  acw_bus_req_t bus;
  acw_conv_ret_t conv;
  logic [7:0] rdata;
  logic conv_start;
  logic tick;
  logic [2:0] ref_sel;
  logic busy;
  logic irq;
  int n_errors;
  int compares;
  int cycles;
  int lat;
  int n;

  acw_control u_dut (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .bus_in(bus), .rdata_out(rdata),
    .trigger_in(trigger_in), .conv_in(conv), .conv_start_out(conv_start),
    .adc_clk_tick_out(tick), .reference_selector_out(ref_sel), .busy_out(busy),
    .irq_out(irq)
  );

  initial
  begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge clk_sys_in);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_in);
    bus.rd <= 1'b0;
    #1;
    chk(16'(rdata), 16'(exp), msg);
  endtask : rchk

  // lat counts cycles from the trigger edge to the start pulse
  task automatic trig(input int lim);
    @(posedge clk_sys_in);
    trigger_in <= 1'b1;
    @(posedge clk_sys_in);
    trigger_in <= 1'b0;
    #1;
    lat = 0;
    while (conv_start !== 1'b1 && lat < lim)
    begin
      step(1);
      lat++;
    end
  endtask : trig

  task automatic dn(input bit smp, input logic [15:0] v);
    @(posedge clk_sys_in);
    conv.sample_done <= smp;
    conv.result_done <= !smp;
    if (smp)
      conv.sample <= v;
    else
      conv.result <= v;
    @(posedge clk_sys_in);
    conv.sample_done <= 1'b0;
    conv.result_done <= 1'b0;
    #1;
  endtask : dn

  function automatic logic win(input logic [2:0] m, input logic [15:0] v);
    case (m)
      ACW_WCM_BELOW: return v < 16'h0100;
      ACW_WCM_ABOVE: return v > 16'h0200;
      ACW_WCM_INSIDE: return v > 16'h0100 && v < 16'h0200;
      ACW_WCM_OUTSIDE: return v < 16'h0100 || v > 16'h0200;
      default: return 1'b0;
    endcase
  endfunction : win

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 7; i++)
      rchk(8'(i), 8'h00, "reset value");
    wr(ACW_OFS_CTRL_WINDOW_COMPARE, 8'h0f);
    rchk(ACW_OFS_CTRL_WINDOW_COMPARE, 8'h0f, "window control");
    wr(ACW_OFS_IRQ_ENABLE, 8'h3f);
    rchk(ACW_OFS_IRQ_ENABLE, 8'h3f, "irq enable");
    wr(ACW_OFS_CONVERTER_STATUS, 8'hff);
    rchk(ACW_OFS_CONVERTER_STATUS, 8'h00, "status written");
    wr(8'h0f, 8'h5a);
    rchk(8'h0f, 8'h00, "unmapped read");
    wr(ACW_OFS_CTRL_WINDOW_COMPARE, 8'h00);
    wr(ACW_OFS_IRQ_ENABLE, 8'h00);
  endtask : t_regs

  task automatic t_div;
    int r;
    for (int c = 0; c < 16; c++)
    begin
      wr(ACW_OFS_CTRL_CLOCK_DIVIDER, 8'(c));
      r = c < 8 ? 2 * c + 2 : (c < 12 ? 4 * c - 12 : 8 * c - 56);
      for (int k = 0; k < 2; k++)
      begin
        step(1);
        n = 1;
        while (tick !== 1'b1 && n < 100)
        begin
          step(1);
          n++;
        end
      end
      chk(16'(n), 16'(r), "divider period");
    end
  endtask : t_div

  task automatic t_settle;
    for (int c = 0; c < 8; c++)
    begin
      wr(ACW_OFS_CTRL_REFERENCE_TIMEBASE, 8'((c < 4 ? 1 : c - 3) * 8 + c));
      step(1);
      chk(16'(ref_sel), 16'(c), "reference copy");
      n = 1;
      while (busy === 1'b1 && n < 400)
      begin
        step(1);
        n++;
      end
      if (c < 4)
        chk(16'(n), 16'h0001, "settling on non-internal code");
      else
        chk(16'(n >= 60 * (c - 3) && n <= 60 * (c - 3) + 4), 16'h0001, "settle");
    end
    wr(ACW_OFS_CTRL_REFERENCE_TIMEBASE, 8'h08);
    wr(ACW_OFS_CTRL_REFERENCE_TIMEBASE, 8'h0c);
    trig(100);
    chk(16'(lat >= 56 && lat <= 62), 16'h0001, "start after settling");
    dn(0, 16'h00a5);
    step(1);
    rchk(ACW_OFS_IRQ_FLAGS, 8'h01, "trigger in settling");
    rchk(ACW_OFS_RESULT_LO, 8'ha5, "result low");
    rchk(ACW_OFS_IRQ_FLAGS, 8'h00, "result read clears");
  endtask : t_settle

  task automatic t_conv;
    wr(ACW_OFS_IRQ_ENABLE, 8'h20);
    trig(5);
    chk(16'(lat), 16'h0000, "idle start");
    // busy is registered from the state, one cycle behind the start pulse
    step(1);
    chk(16'(busy), 16'h0001, "busy converting");
    trig(5);
    dn(1, 16'h1234);
    dn(1, 16'h1235);
    dn(0, 16'habcd);
    step(1);
    rchk(ACW_OFS_IRQ_FLAGS, 8'h33, "overrun flags");
    chk(16'(irq), 16'h0001, "irq raised");
    wr(ACW_OFS_IRQ_FLAGS, 8'h00);
    rchk(ACW_OFS_IRQ_FLAGS, 8'h33, "write zero keeps");
    rchk(ACW_OFS_SAMPLE_LO, 8'h35, "sample low");
    rchk(ACW_OFS_SAMPLE_HI, 8'h12, "sample high");
    rchk(ACW_OFS_IRQ_FLAGS, 8'h31, "sample read clears");
    rchk(ACW_OFS_RESULT_HI, 8'hab, "result high");
    rchk(ACW_OFS_IRQ_FLAGS, 8'h30, "result read clears");
    trig(5);
    dn(0, 16'h0001);
    trig(5);
    // clear and new result in one cycle: the set must survive
    @(posedge clk_sys_in);
    bus <= '{addr: ACW_OFS_IRQ_FLAGS, wdata: 8'h01, wr: 1'b1, rd: 1'b0};
    conv.result_done <= 1'b1;
    @(posedge clk_sys_in);
    bus.wr <= 1'b0;
    conv.result_done <= 1'b0;
    step(1);
    rchk(ACW_OFS_IRQ_FLAGS, 8'h39, "overwrite and set priority");
    wr(ACW_OFS_IRQ_ENABLE, 8'h00);
    step(1);
    chk(16'(irq), 16'h0000, "irq masked");
    wr(ACW_OFS_IRQ_ENABLE, 8'h08);
    step(1);
    chk(16'(irq), 16'h0001, "irq unmasked");
    wr(ACW_OFS_IRQ_FLAGS, 8'h08);
    step(1);
    chk(16'(irq), 16'h0000, "irq cleared");
    wr(ACW_OFS_IRQ_FLAGS, 8'h3f);
    rchk(ACW_OFS_IRQ_FLAGS, 8'h00, "all cleared");
  endtask : t_conv

  task automatic t_window;
    logic [15:0] vals [5] = '{16'h00ff, 16'h0100, 16'h0150, 16'h0200, 16'h0201};
    logic [15:0] v;
    logic [7:0] e;
    wr(ACW_OFS_LOW_THRESH_HI, 8'h01);
    wr(ACW_OFS_HIGH_THRESH_HI, 8'h02);
    // unread sample and result so every pass sets both overwrite flags
    dn(1, 16'h0000);
    for (int s = 0; s < 2; s++)
      for (int m = 0; m < 8; m++)
      begin
        wr(ACW_OFS_CTRL_WINDOW_COMPARE, 8'(s * 8 + m));
        for (int k = 0; k < 5; k++)
        begin
          v = vals[k];
          trig(5);
          dn(1, s ? v : ~v);
          dn(0, s ? ~v : v);
          step(1);
          e = 8'h1b | {5'h00, win(3'(m), v), 2'h0};
          rchk(ACW_OFS_IRQ_FLAGS, e, "window");
          wr(ACW_OFS_IRQ_FLAGS, 8'h3f);
        end
      end
  endtask : t_window

  task automatic t_off;
    wr(ACW_OFS_CTRL_ENABLE, 8'h00);
    trig(5);
    chk(16'(lat), 16'h0005, "no start when disabled");
    dn(1, 16'h0050);
    dn(0, 16'h0050);
    step(1);
    rchk(ACW_OFS_IRQ_FLAGS, 8'h00, "no flags when disabled");
    chk(16'(busy), 16'h0000, "idle when disabled");
  endtask : t_off

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      n_errors++;
      final_report;
    end
  end

  initial
  begin
    n_errors = 0;
    compares = 0;
    cycles = 0;
    rst_in = 1'b1;
    trigger_in = 1'b0;
    bus = '0;
    conv = '0;
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    #1;
    t_regs;
    wr(ACW_OFS_CTRL_ENABLE, 8'h01);
    t_div;
    t_settle;
    t_conv;
    t_window;
    t_off;
    final_report;
  end
endmodule : adc_control_window_irq_bench
